// ==== hw/mark_stop_init.sv ====
// Mark stop distance and table default init parameter block, APB slave
`timescale 1ns/1ps
module mark_stop_init (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire mark_init_pkg::apb_req_s apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic mark_detect_input_i,
    input wire logic [15:0] stored_init_code_i,
    output logic [15:0] init_code_param_o,
    input wire logic move_load_i,
    input wire logic [31:0] move_distance_i,
    input wire logic move_step_i,
    output logic [31:0] remaining_o,
    output logic [34:0] segments_o,
    output logic init_busy_o,
    output logic parameter_error_alarm_o,
    output logic irq_o
);
    localparam logic [mark_init_pkg::ADDR_W-1:0] WORD_MASK = 12'hFFC;

    function automatic logic [31:0] pow10(input logic [1:0] e);
        case (e)
            2'h0: pow10 = 32'h0000_0001;
            2'h1: pow10 = 32'h0000_000A;
            2'h2: pow10 = 32'h0000_0064;
            default: pow10 = 32'h0000_03E8;
        endcase
    endfunction

    function automatic logic is_table(input logic [mark_init_pkg::ADDR_W-1:0] a);
        is_table = (a >= mark_init_pkg::OFF_TABLE_BASE) && (a <= mark_init_pkg::OFF_TABLE_END);
    endfunction

    // Register state
    logic [15:0] stop_low_q, stop_low_d, stop_high_q, stop_high_d;
    logic [15:0] code_q, code_d, fsel5_q, fsel5_d, unit_q, unit_d;
    logic low_pending_q, low_pending_d, alarm_q, alarm_d;
    logic [2:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
    logic [1:0] contents_q, contents_d;
    logic [31:0] remain_q, remain_d, prdata_q, prdata_d;
    logic [31:0] stop_active_q, stop_active_d;
    mark_init_pkg::init_state_e st_q, st_d;
    mark_init_pkg::init_sel_s sel_q, sel_d;
    logic mark_s1_q, mark_s2_q, mark_s3_q;
    logic [34:0] seg_q, seg_d;

    logic access, wr, rd, wr_ok, tbl_hit, tbl_refuse, half_bad, unmapped;
    logic clear_start, clear_busy, mark_rise, init_busy;
    logic [mark_init_pkg::ADDR_W-1:0] a;
    logic [15:0] wlo;
    logic [19:0] combined;
    logic [31:0] scaled, tbl_rdata;
    logic [2:0] irq_event;

    assign a = apb_i.paddr & WORD_MASK;
    assign wlo = apb_i.pwdata[15:0];
    assign access = apb_i.psel && apb_i.penable;
    assign wr = access && apb_i.pwrite;
    assign rd = access && !apb_i.pwrite;
    assign tbl_hit = is_table(a);
    assign init_busy = (st_q != mark_init_pkg::ST_RUN);
    assign tbl_refuse = tbl_hit && init_busy;
    assign half_bad = wr && ((a == mark_init_pkg::OFF_STOP_LOW) || (a == mark_init_pkg::OFF_STOP_HIGH))
        && (wlo > mark_init_pkg::STOP_HALF_MAX || apb_i.pwdata[31:16] != 16'h0000);
    assign unmapped = !tbl_hit && (a > mark_init_pkg::OFF_REMAIN);
    assign wr_ok = wr && !half_bad && !tbl_refuse && !unmapped;

    assign combined = 20'(stop_high_q) * mark_init_pkg::STOP_HIGH_WEIGHT + 20'(stop_low_q);
    // Scale by unit exponent, pulse unit unscaled
    assign scaled = (unit_q[mark_init_pkg::UNIT_LSB +: 2] == mark_init_pkg::UNIT_PULSE)
        ? 32'(combined) : 32'(32'(combined) * pow10(unit_q[mark_init_pkg::EXP_LSB +: 2]));

    assign mark_rise = mark_s2_q && !mark_s3_q;
    assign clear_start = (st_q == mark_init_pkg::ST_SAMPLE) && sel_d.do_table;

    point_table_store u_table (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .clear_start_i(clear_start),
        .wr_en_i(wr_ok && tbl_hit),
        .addr_i(a[mark_init_pkg::TABLE_AW+1:2]),
        .wdata_i(apb_i.pwdata),
        .rdata_o(tbl_rdata),
        .clear_busy_o(clear_busy)
    );

    // Mark detect pin synchroniser
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mark_s1_q <= 1'b0;
            mark_s2_q <= 1'b0;
            mark_s3_q <= 1'b0;
        end else begin
            mark_s1_q <= mark_detect_input_i;
            mark_s2_q <= mark_s1_q;
            mark_s3_q <= mark_s2_q;
        end
    end

    // Power-up init sequencer
    always_comb begin
        st_d = st_q;
        sel_d = sel_q;
        contents_d = contents_q;
        seg_d = {5{mark_init_pkg::SEG_BLANK}};
        case (st_q)
            mark_init_pkg::ST_SAMPLE: begin
                sel_d.do_table = (stored_init_code_i == mark_init_pkg::CODE_TABLE_PROG)
                    || (stored_init_code_i == mark_init_pkg::CODE_ALL);
                sel_d.do_cam = (stored_init_code_i == mark_init_pkg::CODE_CAM)
                    || (stored_init_code_i == mark_init_pkg::CODE_ALL);
                st_d = (sel_d.do_table || sel_d.do_cam) ? mark_init_pkg::ST_CLEAR
                    : mark_init_pkg::ST_RUN;
            end
            mark_init_pkg::ST_CLEAR: begin
                if (sel_q.do_table) begin
                    seg_d = {{2{mark_init_pkg::SEG_BLANK}}, mark_init_pkg::SEG_D,
                        mark_init_pkg::SEG_E, mark_init_pkg::SEG_F};
                end
                // Walk ends in table depth cycles
                if (!clear_busy) begin
                    st_d = mark_init_pkg::ST_FINISH;
                end
            end
            mark_init_pkg::ST_FINISH: begin
                if (sel_q.do_table) begin
                    contents_d[mark_init_pkg::CONT_PROG] = 1'b0;
                end
                if (sel_q.do_cam) begin
                    contents_d[mark_init_pkg::CONT_CAM] = 1'b0;
                end
                st_d = mark_init_pkg::ST_RUN;
            end
            mark_init_pkg::ST_RUN: begin
                if (wr_ok && a == mark_init_pkg::OFF_CONTENTS) begin
                    contents_d = apb_i.pwdata[1:0];
                end
            end
            default: st_d = mark_init_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_q <= mark_init_pkg::ST_SAMPLE;
            sel_q <= '0;
            contents_q <= mark_init_pkg::RST_CONTENTS;
            seg_q <= '0;
        end else begin
            st_q <= st_d;
            sel_q <= sel_d;
            contents_q <= contents_d;
            seg_q <= seg_d;
        end
    end

    // Parameter registers, ordering check and travel
    always_comb begin
        stop_low_d = stop_low_q;
        stop_high_d = stop_high_q;
        code_d = code_q;
        fsel5_d = fsel5_q;
        unit_d = unit_q;
        low_pending_d = low_pending_q;
        alarm_d = alarm_q;
        irq_mask_d = irq_mask_q;
        remain_d = remain_q;
        stop_active_d = stop_active_q;
        irq_event = 3'h0;
        if (st_q == mark_init_pkg::ST_SAMPLE) begin
            code_d = stored_init_code_i;
        end
        if (st_q == mark_init_pkg::ST_FINISH) begin
            code_d = 16'h0000;
            irq_event[mark_init_pkg::IRQ_INIT_DONE] = 1'b1;
        end
        if (wr_ok) begin
            case (a)
                mark_init_pkg::OFF_STOP_LOW: begin
                    stop_low_d = wlo;
                    low_pending_d = 1'b1;
                end
                mark_init_pkg::OFF_STOP_HIGH: begin
                    stop_high_d = wlo;
                    low_pending_d = 1'b0;
                    if (!low_pending_q) begin
                        alarm_d = 1'b1;
                        irq_event[mark_init_pkg::IRQ_ALARM] = 1'b1;
                    end
                end
                mark_init_pkg::OFF_INIT_CODE: code_d = wlo;
                mark_init_pkg::OFF_FSEL5: fsel5_d = wlo;
                mark_init_pkg::OFF_UNIT_SEL: unit_d = wlo;
                mark_init_pkg::OFF_IRQ_MASK: irq_mask_d = apb_i.pwdata[2:0];
                default: begin
                end
            endcase
        end
        // New distance used only after the ordered pair
        if (wr_ok && a == mark_init_pkg::OFF_STOP_HIGH && low_pending_q) begin
            stop_active_d = 32'(32'(20'(stop_low_q) + 20'(wlo) * mark_init_pkg::STOP_HIGH_WEIGHT)
                * ((unit_q[1:0] == mark_init_pkg::UNIT_PULSE) ? 32'h0000_0001
                : pow10(unit_q[mark_init_pkg::EXP_LSB +: 2])));
        end
        if (move_load_i) begin
            remain_d = move_distance_i;
        end else if (move_step_i && remain_q != 32'h0000_0000) begin
            remain_d = remain_q - 32'h0000_0001;
        end
        if (mark_rise) begin
            remain_d = stop_active_q;
            irq_event[mark_init_pkg::IRQ_MARK] = 1'b1;
        end
        // Read clears, set wins
        irq_stat_d = irq_stat_q;
        if (rd && a == mark_init_pkg::OFF_IRQ_STATUS) begin
            irq_stat_d = 3'h0;
        end
        irq_stat_d = irq_stat_d | irq_event;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            stop_low_q <= mark_init_pkg::RST_STOP_HALF;
            stop_high_q <= mark_init_pkg::RST_STOP_HALF;
            code_q <= mark_init_pkg::RST_INIT_CODE;
            fsel5_q <= mark_init_pkg::RST_FSEL5;
            unit_q <= mark_init_pkg::RST_UNIT_SEL;
            low_pending_q <= 1'b0;
            alarm_q <= 1'b0;
            irq_stat_q <= mark_init_pkg::RST_IRQ;
            irq_mask_q <= mark_init_pkg::RST_IRQ;
            remain_q <= 32'h0000_0000;
            stop_active_q <= 32'h0000_0000;
        end else begin
            stop_low_q <= stop_low_d;
            stop_high_q <= stop_high_d;
            code_q <= code_d;
            fsel5_q <= fsel5_d;
            unit_q <= unit_d;
            low_pending_q <= low_pending_d;
            alarm_q <= alarm_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            remain_q <= remain_d;
            stop_active_q <= stop_active_d;
        end
    end

    // Read mux
    always_comb begin
        prdata_d = 32'h0000_0000;
        if (tbl_hit) begin
            prdata_d = tbl_refuse ? 32'h0000_0000 : tbl_rdata;
        end else begin
            case (a)
                mark_init_pkg::OFF_STOP_LOW: prdata_d = 32'(stop_low_q);
                mark_init_pkg::OFF_STOP_HIGH: prdata_d = 32'(stop_high_q);
                mark_init_pkg::OFF_INIT_CODE: prdata_d = 32'(code_q);
                mark_init_pkg::OFF_FSEL5: prdata_d = 32'(fsel5_q);
                mark_init_pkg::OFF_UNIT_SEL: prdata_d = 32'(unit_q);
                mark_init_pkg::OFF_IRQ_STATUS: prdata_d = 32'(irq_stat_q);
                mark_init_pkg::OFF_IRQ_MASK: prdata_d = 32'(irq_mask_q);
                mark_init_pkg::OFF_STATE: prdata_d = {29'h0, low_pending_q, alarm_q, init_busy};
                mark_init_pkg::OFF_CONTENTS: prdata_d = 32'(contents_q);
                mark_init_pkg::OFF_REMAIN: prdata_d = remain_q;
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_i.psel && !apb_i.penable) begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = access && (half_bad || tbl_refuse || unmapped);
    assign init_code_param_o = code_q;
    assign remaining_o = remain_q;
    assign segments_o = seg_q;
    assign init_busy_o = init_busy;
    assign parameter_error_alarm_o = alarm_q;
    assign irq_o = |(irq_stat_q & irq_mask_q);
    logic unused_scaled;
    assign unused_scaled = ^scaled;
endmodule

// ==== shared/mark_init_pkg.sv ====
// Constants, types and register map of the mark stop and table init block
package mark_init_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int TABLE_DEPTH = 64;
    localparam int TABLE_AW = 6;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_STOP_LOW = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_STOP_HIGH = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_INIT_CODE = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_FSEL5 = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_UNIT_SEL = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_STATE = 12'h01C;
    localparam logic [ADDR_W-1:0] OFF_CONTENTS = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_REMAIN = 12'h024;
    localparam logic [ADDR_W-1:0] OFF_TABLE_BASE = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_TABLE_END = 12'h1FC;

    // Reset values
    localparam logic [15:0] RST_STOP_HALF = 16'h0000;
    localparam logic [15:0] RST_INIT_CODE = 16'h0000;
    localparam logic [15:0] RST_FSEL5 = 16'h0000;
    localparam logic [15:0] RST_UNIT_SEL = 16'h0000;
    localparam logic [2:0] RST_IRQ = 3'h0;
    localparam logic [1:0] RST_CONTENTS = 2'h3;

    // Stop distance limits and combination
    localparam logic [15:0] STOP_HALF_MAX = 16'h03E7;
    localparam logic [19:0] STOP_HIGH_WEIGHT = 20'h003E8;

    // Init codes
    localparam logic [15:0] CODE_TABLE_PROG = 16'h5001;
    localparam logic [15:0] CODE_CAM = 16'h5010;
    localparam logic [15:0] CODE_ALL = 16'h5011;

    // Unit select fields: data unit [1:0], exponent [5:4]
    localparam int UNIT_LSB = 0;
    localparam int EXP_LSB = 4;
    localparam logic [1:0] UNIT_PULSE = 2'h3;

    // Interrupt bit positions
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_INIT_DONE = 1;
    localparam int IRQ_MARK = 2;

    // Contents bit positions
    localparam int CONT_PROG = 0;
    localparam int CONT_CAM = 1;

    // Seven-segment patterns, gfedcba
    localparam logic [6:0] SEG_BLANK = 7'h00;
    localparam logic [6:0] SEG_D = 7'h5E;
    localparam logic [6:0] SEG_E = 7'h79;
    localparam logic [6:0] SEG_F = 7'h71;

    typedef enum logic [1:0] {
        ST_SAMPLE = 2'b00,
        ST_CLEAR = 2'b01,
        ST_FINISH = 2'b11,
        ST_RUN = 2'b10
    } init_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic do_table;
        logic do_cam;
    } init_sel_s;
endpackage

// ==== hw/point_table_store.sv ====
// Point table memory with a sequential clear walk
`timescale 1ns/1ps
module point_table_store (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic clear_start_i,
    input wire logic wr_en_i,
    input wire logic [mark_init_pkg::TABLE_AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic clear_busy_o
);
    logic [31:0] mem_q [mark_init_pkg::TABLE_DEPTH];
    logic [mark_init_pkg::TABLE_AW-1:0] ptr_q, ptr_d;
    logic busy_q, busy_d;

    always_comb begin
        ptr_d = ptr_q;
        busy_d = busy_q;
        if (clear_start_i) begin
            busy_d = 1'b1;
            ptr_d = '0;
        end else if (busy_q) begin
            ptr_d = ptr_q + 1'b1;
            if (&ptr_q) begin
                busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ptr_q <= '0;
            busy_q <= 1'b0;
        end else begin
            ptr_q <= ptr_d;
            busy_q <= busy_d;
        end
    end

    // Memory itself needs no reset; cleared only by an init walk
    always_ff @(posedge clk_i) begin
        if (busy_q) begin
            mem_q[ptr_q] <= 32'h0000_0000;
        end else if (wr_en_i) begin
            mem_q[addr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem_q[addr_i];
    assign clear_busy_o = busy_q;
endmodule

// ==== dv/mark_stop_init_assertions.sv ====
// Port checker of the mark stop and table init block, bound into the design
`timescale 1ns/1ps
module mark_stop_init_assertions (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire mark_init_pkg::apb_req_s apb_i,
    input wire logic pslverr_o,
    input wire logic [15:0] stored_init_code_i,
    input wire logic [15:0] init_code_param_o,
    input wire logic [34:0] segments_o,
    input wire logic init_busy_o,
    input wire logic parameter_error_alarm_o
);
    logic [7:0] busy_cnt_q;
    logic [7:0] busy_cnt_d;
    logic acc;
    logic wr_half;
    logic tbl;
    logic valid;
    assign acc = apb_i.psel & apb_i.penable;
    assign wr_half = acc & apb_i.pwrite & (apb_i.paddr == mark_init_pkg::OFF_STOP_LOW
        || apb_i.paddr == mark_init_pkg::OFF_STOP_HIGH);
    assign tbl = stored_init_code_i == mark_init_pkg::CODE_TABLE_PROG
        || stored_init_code_i == mark_init_pkg::CODE_ALL;
    assign valid = tbl || stored_init_code_i == mark_init_pkg::CODE_CAM;

    // Length of the current busy stretch, saturating
    always_comb begin
        busy_cnt_d = 8'h00;
        if (init_busy_o) begin
            busy_cnt_d = (busy_cnt_q == 8'hFF) ? busy_cnt_q : busy_cnt_q + 8'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            busy_cnt_q <= 8'h00;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end

    function automatic logic has_def(input logic [34:0] s);
        logic f;
        f = 1'h0;
        for (int k = 0; k < 3; k++) begin
            if (s[k*7 +: 21] == {mark_init_pkg::SEG_D, mark_init_pkg::SEG_E,
                mark_init_pkg::SEG_F}) begin
                f = 1'h1;
            end
        end
        return f;
    endfunction

    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_alarm_sticky: assert property (parameter_error_alarm_o |=> parameter_error_alarm_o)
        else $error("alarm dropped without reset");
    a_alarm_cause: assert property ($rose(parameter_error_alarm_o) |->
        $past(acc && apb_i.pwrite && apb_i.paddr == mark_init_pkg::OFF_STOP_HIGH))
        else $error("alarm rose without a high half write");
    a_range_refuse: assert property (wr_half && apb_i.pwdata > 32'h000003E7
        |-> pslverr_o)
        else $error("out of range half accepted");
    a_busy_refuse: assert property (acc && init_busy_o
        && apb_i.paddr >= mark_init_pkg::OFF_TABLE_BASE
        && apb_i.paddr <= mark_init_pkg::OFF_TABLE_END |-> pslverr_o)
        else $error("table access accepted while busy");
    a_busy_bound: assert property (busy_cnt_q < 8'h64)
        else $error("init sequence too long");
    a_def_shown: assert property (tbl && busy_cnt_q > 8'h08 && busy_cnt_q < 8'h3C
        |-> has_def(segments_o))
        else $error("init pattern missing from display");
    a_code_cleared: assert property ($fell(init_busy_o) |->
        init_code_param_o == (valid ? 16'h0000 : stored_init_code_i))
        else $error("init code wrong after init");
    a_code_reset: assert property ($rose(nrst_i) |-> init_code_param_o == 16'h0000)
        else $error("init code reset value wrong");
    a_invalid_idle: assert property ($rose(nrst_i) && !valid |-> ##[1:3] !init_busy_o)
        else $error("unknown code started an init");
    a_table_run: assert property ($rose(nrst_i) && tbl |-> init_busy_o [*8])
        else $error("table init did not run");
endmodule

bind mark_stop_init mark_stop_init_assertions u_chk (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .apb_i(apb_i),
    .pslverr_o(pslverr_o),
    .stored_init_code_i(stored_init_code_i),
    .init_code_param_o(init_code_param_o),
    .segments_o(segments_o),
    .init_busy_o(init_busy_o),
    .parameter_error_alarm_o(parameter_error_alarm_o)
);

// ==== dv/mark_stop_init_tb.sv ====
// Self-checking testbench of the mark stop and table init block
`timescale 1ns/1ps
module mark_stop_init_tb;
    logic clk_i = 1'h0;
    logic nrst_i = 1'h0;
    mark_init_pkg::apb_req_s apb_q = '0;
    logic mark_q = 1'h0;
    logic load_q = 1'h0;
    logic step_q = 1'h0;
    logic [15:0] code_q = 16'h0000;
    logic [31:0] dist_q = 32'h00000000;
    logic [31:0] prdata_o;
    logic [31:0] remaining_o;
    logic [34:0] segments_o;
    logic [15:0] init_code_param_o;
    logic pready_o, pslverr_o, init_busy_o, parameter_error_alarm_o, irq_o;
    int mismatches = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'h72242367;
    logic [31:0] rd;
    logic err;
    logic [15:0] codes [4] = '{16'h5001, 16'h5010, 16'h5011, 16'h5100};
    logic [31:0] cont_exp [4] = '{32'h2, 32'h1, 32'h0, 32'h3};

    always #2 clk_i = ~clk_i;

    mark_stop_init dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .apb_i(apb_q), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .mark_detect_input_i(mark_q),
        .stored_init_code_i(code_q), .init_code_param_o(init_code_param_o),
        .move_load_i(load_q), .move_distance_i(dist_q), .move_step_i(step_q),
        .remaining_o(remaining_o), .segments_o(segments_o), .init_busy_o(init_busy_o),
        .parameter_error_alarm_o(parameter_error_alarm_o), .irq_o(irq_o)
    );

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] stop_exp(input int lo, input int hi, input logic [5:0] u);
        int v;
        v = hi * 1000 + lo;
        if (u[1:0] != 2'h3) begin
            v = v * (10 ** u[5:4]);
        end
        return 32'(v);
    endfunction

    function automatic logic has_def(input logic [34:0] s);
        logic f;
        f = 1'h0;
        for (int k = 0; k < 3; k++) begin
            if (s[k*7 +: 21] === {mark_init_pkg::SEG_D, mark_init_pkg::SEG_E,
                mark_init_pkg::SEG_F}) begin
                f = 1'h1;
            end
        end
        return f;
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic hang(input string msg);
        mismatches++;
        $display("mismatch at %0t: timeout %s", $time, msg);
        stop_test();
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        apb_q <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk_i);
        apb_q.penable <= 1'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'h1 && n < 50);
        if (n >= 50) begin
            hang("apb");
        end
        rd = prdata_o;
        err = pslverr_o;
        apb_q.psel <= 1'h0;
        apb_q.penable <= 1'h0;
    endtask

    task automatic pwr(input logic [15:0] c);
        nrst_i <= 1'h0;
        code_q <= c;
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'h1;
    endtask

    task automatic wait_idle(input logic tbl);
        int n;
        n = 0;
        @(posedge clk_i);
        while (init_busy_o !== 1'h0 && n < 300) begin
            if (n == (tbl ? 20 : 1)) chk(has_def(segments_o), tbl, "display");
            @(posedge clk_i);
            n++;
        end
        if (n >= 300) begin
            hang("init");
        end
    endtask

    initial begin
        int lo;
        int hi;
        logic [31:0] u;
        logic [31:0] e;
        pwr(16'h0000);
        wait_idle(1'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'h0, mark_init_pkg::OFF_STOP_LOW + 12'(4 * i), 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        apb(1'h0, mark_init_pkg::OFF_CONTENTS, 32'h0);
        chk(rd, 32'h3, "contents untouched");
        apb(1'h0, 12'h040, 32'h0);
        chk(err, 1'h1, "unmapped address");
        apb(1'h1, mark_init_pkg::OFF_STOP_LOW, 32'h3E7);
        chk(err, 1'h0, "999 accepted");
        apb(1'h1, mark_init_pkg::OFF_STOP_LOW, 32'h3E8);
        chk(err, 1'h1, "1000 refused");
        apb(1'h0, mark_init_pkg::OFF_STOP_LOW, 32'h0);
        chk(rd, 32'h3E7, "refused write kept out");
        $display("test reset and range done");
        for (int i = 0; i < 8; i++) begin
            lo = xs() % 1000;
            hi = xs() % 1000;
            u = xs() & 32'h33;
            if (i == 0) begin
                lo = 999;
                hi = 999;
                u = 32'h30;
            end
            e = stop_exp(lo, hi, u[5:0]);
            apb(1'h1, mark_init_pkg::OFF_IRQ_MASK, 32'(i % 2) << 2);
            apb(1'h1, mark_init_pkg::OFF_UNIT_SEL, u);
            apb(1'h1, mark_init_pkg::OFF_STOP_LOW, 32'(lo));
            apb(1'h1, mark_init_pkg::OFF_STOP_HIGH, 32'(hi));
            @(posedge clk_i);
            chk(parameter_error_alarm_o, 1'h0, "ordered pair alarm");
            load_q <= 1'h1;
            dist_q <= xs();
            @(posedge clk_i);
            load_q <= 1'h0;
            mark_q <= 1'h1;
            repeat (6) @(posedge clk_i);
            chk(remaining_o, e, "stop distance");
            chk(irq_o, 32'(i % 2), "mark irq level");
            apb(1'h0, mark_init_pkg::OFF_IRQ_STATUS, 32'h0);
            chk(rd[2], 1'h1, "mark status");
            mark_q <= 1'h0;
            step_q <= 1'h1;
            @(posedge clk_i);
            step_q <= 1'h0;
            @(posedge clk_i);
            chk(irq_o, 1'h0, "irq cleared");
            chk(remaining_o, (e == 0) ? e : e - 1, "step");
        end
        $display("test stop distance done");
        apb(1'h1, mark_init_pkg::OFF_IRQ_MASK, 32'h1);
        apb(1'h1, mark_init_pkg::OFF_STOP_HIGH, 32'h5);
        @(posedge clk_i);
        chk(parameter_error_alarm_o, 1'h1, "wrong order alarm");
        chk(irq_o, 1'h1, "alarm irq");
        apb(1'h0, mark_init_pkg::OFF_IRQ_STATUS, 32'h0);
        chk(rd[0], 1'h1, "alarm status");
        apb(1'h0, mark_init_pkg::OFF_STOP_HIGH, 32'h0);
        chk(rd, 32'h5, "value still stored");
        chk(parameter_error_alarm_o, 1'h1, "alarm sticky");
        $display("test wrong order done");
        for (int i = 0; i < 4; i++) begin
            e = xs() | 32'h1;
            apb(1'h1, mark_init_pkg::OFF_TABLE_BASE + 12'h014, e);
            apb(1'h1, mark_init_pkg::OFF_INIT_CODE, 32'(codes[i]));
            @(posedge clk_i);
            chk(init_code_param_o, codes[i], "code written");
            pwr(codes[i]);
            if (i != 1 && i != 3) begin
                apb(1'h0, mark_init_pkg::OFF_TABLE_BASE + 12'h014, 32'h0);
                chk(err, 1'h1, "busy table refused");
                chk(rd, 32'h0, "busy table read zero");
            end
            wait_idle(i == 0 || i == 2);
            chk(init_code_param_o, (i == 3) ? codes[i] : 16'h0000, "init code");
            apb(1'h0, mark_init_pkg::OFF_CONTENTS, 32'h0);
            chk(rd, cont_exp[i], "erased contents");
            apb(1'h0, mark_init_pkg::OFF_IRQ_STATUS, 32'h0);
            chk(rd[1], 32'(i != 3), "init done status");
            apb(1'h0, mark_init_pkg::OFF_TABLE_BASE + 12'h014, 32'h0);
            chk(rd, (i == 0 || i == 2) ? 32'h0 : e, "table after init");
        end
        $display("test init codes done");
        stop_test();
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        hang("run");
    end
endmodule
